// ===== tbc_ctrl.v
// Power-mode state machine, APB register file and output control of the bias generator
`timescale 1ns/1ps
`default_nettype none
`include "tbc_map.vh"

module tbc_ctrl #(
  parameter STARTUP_CYC = `TBC_STARTUP_CYC  // Startup dwell; shorten for simulation
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Supply sense pin
  input  wire        io_reference_supply,
  // Boost converter control
  output reg         boost_en,
  output reg  [3:0]  boost_code,
  output reg  [7:0]  boosted_rail_volts,
  // Output channels A, B, C in bits 0, 1, 2
  output reg  [2:0]  out_drive,
  output reg  [2:0]  out_pulldown,
  output reg  [20:0] out_level,
  output reg  [2:0]  out_hiz,
  // Mode indication
  output reg  [1:0]  power_state_field,
  output reg         serial_on
);

  // One-hot state codes
  localparam [3:0] ST_SHUT  = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_ACT   = 4'h4;
  localparam [3:0] ST_LOW   = 4'h8;

  // Wide enough for the default dwell count
  localparam CW = 16;

  // Decodes an APB offset to a one-hot register select
  function [6:0] reg_sel;
    input [11:0] a;
    begin
      reg_sel = 7'h00;
      case (a)
        `TBC_OFF_MODE:    reg_sel = 7'h01;
        `TBC_OFF_BOOST:   reg_sel = 7'h02;
        `TBC_OFF_ENABLE:  reg_sel = 7'h04;
        `TBC_OFF_LEVEL_A: reg_sel = 7'h08;
        `TBC_OFF_LEVEL_B: reg_sel = 7'h10;
        `TBC_OFF_LEVEL_C: reg_sel = 7'h20;
        `TBC_OFF_STATUS:  reg_sel = 7'h40;
        default:          reg_sel = 7'h00;
      endcase
    end
  endfunction

  wire          vio_s;       // Synchronised supply sense
  reg           vio_d_r;     // Previous supply level, for edge finding
  reg  [3:0]    state_r;     // Power state
  reg  [3:0]    state_nxt;
  reg  [CW-1:0] cnt_r;       // Startup dwell counter
  reg  [3:0]    boost_r;     // Boost level code
  reg  [2:0]    en_r;        // Channel enables
  reg  [20:0]   lvl_r;       // Three level codes packed A,B,C
  reg           ap_pend_r;   // Access phase already answered
  wire          setup_ok;    // Registers live and not in shutdown
  wire          acc;         // Access phase cycle
  wire          wr;          // Write taking effect
  wire [6:0]    sel;         // Decoded register
  wire [1:0]    req;         // Requested power code
  wire          soft_rst;    // Software startup request
  wire          vio_rise;    // Supply just came up

  // The supply pin is asynchronous, so it passes two flops first
  tbc_sync #(.RST_VAL(1'b0)) u_vio_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d_in    (io_reference_supply),
    .q_out   (vio_s)
  );

  assign acc      = psel & penable & ~ap_pend_r;
  assign sel      = reg_sel(paddr);
  assign setup_ok = (state_r != ST_SHUT);
  assign wr       = acc & pwrite & setup_ok;
  assign req      = pwdata[1:0];
  assign vio_rise = vio_s & ~vio_d_r;
  // Startup request is honoured from active or low power only
  assign soft_rst = wr & sel[0] & (req == `TBC_PM_STARTUP) &
                    ((state_r == ST_ACT) | (state_r == ST_LOW));

  // Supply edge memory
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vio_d_r <= 1'b0;
    end else begin
      vio_d_r <= vio_s;
    end
  end

  // Next power state
  // Shutdown is the resting state after reset and whenever the synchronised
  // supply sense reads low. Only a low-to-high step of that sense leaves it,
  // so a supply that is already present at reset release still counts as a
  // rise because the edge memory resets low.
  // Startup is a fixed dwell of STARTUP_CYC cycles; the counter runs only
  // while the state stays in startup and clears at every other time, so a
  // restart from software always gets the full dwell again.
  // A write that requests startup while already in startup is ignored; the
  // dwell is never extended by software.
  // From active, software may ask for low power or for a restart; from low
  // power it may ask for active or for a restart. Every other code written
  // to the mode register is dropped silently and raises no bus error, which
  // keeps a confused driver from wedging the part in an odd state.
  // The supply check sits after the case so that it overrides any request
  // taken in the same cycle.
  // Unused one-hot codes fall back to shutdown through the default branch.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_SHUT: begin
        // Power-up lands here; rising supply starts up
        if (vio_rise) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        // Transitory: leave once the dwell has elapsed
        if (cnt_r == STARTUP_CYC[CW-1:0] - 1'b1) begin
          state_nxt = ST_ACT;
        end
      end
      ST_ACT: begin
        if (wr & sel[0] & (req == `TBC_PM_LOWPWR)) begin
          state_nxt = ST_LOW;
        end else if (soft_rst) begin
          state_nxt = ST_START;
        end
        // Other codes leave the mode unchanged
      end
      ST_LOW: begin
        if (wr & sel[0] & (req == `TBC_PM_ACTIVE)) begin
          state_nxt = ST_ACT;
        end else if (soft_rst) begin
          state_nxt = ST_START;
        end
        // Low power to low power or shutdown requests are dropped
      end
      default: begin
        state_nxt = ST_SHUT;
      end
    endcase
    // Supply low wins over everything else
    if (!vio_s) begin
      state_nxt = ST_SHUT;
    end
  end

  // State and dwell counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_SHUT;
      cnt_r   <= {CW{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_START && state_nxt == ST_START) begin
        cnt_r <= cnt_r + 1'b1;
      end else begin
        cnt_r <= {CW{1'b0}};
      end
    end
  end

  // Retention policy: shutdown and the first cycle of every startup load the
  // defaults, so nothing written before a supply loss or a software restart
  // survives. Low power takes no special branch at all, which is what keeps
  // every register intact through it; writes are even accepted there, so a
  // driver may stage new levels before returning to active.
  // Writes in startup are accepted as well, because the bus must work in that
  // mode, but a write that lands in the entry cycle loses to the defaults.
  // Level codes are packed A, B, C from the low bits upward.
  // Register file; defaults forced in shutdown and on every startup entry
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_r <= `TBC_BOOST_RST;
      en_r    <= `TBC_ENABLE_RST;
      lvl_r   <= {3{`TBC_LEVEL_RST}};
    end else if (state_r == ST_SHUT || state_nxt == ST_START && state_r != ST_START) begin
      // Contents are not kept through shutdown or a restart
      boost_r <= `TBC_BOOST_RST;
      en_r    <= `TBC_ENABLE_RST;
      lvl_r   <= {3{`TBC_LEVEL_RST}};
    end else if (wr) begin
      // Low power falls through here too, so contents persist
      if (sel[1]) begin
        boost_r <= pwdata[3:0];
      end
      if (sel[2]) begin
        en_r <= pwdata[2:0];
      end
      if (sel[3]) begin
        lvl_r[6:0] <= pwdata[6:0];
      end
      if (sel[4]) begin
        lvl_r[13:7] <= pwdata[6:0];
      end
      if (sel[5]) begin
        lvl_r[20:14] <= pwdata[6:0];
      end
    end
  end

  // Bus timing: the access phase is taken at the first edge that sees psel
  // and penable together, and the answer follows one cycle later with pready,
  // pslverr and prdata standing for exactly that cycle. The pending flag
  // stops a master that holds penable for an extra cycle from being answered
  // twice. Every access in shutdown ends with an error and writes nothing;
  // a fixed single wait state costs one cycle per access but keeps prdata and
  // pready straight from flops.
  // A slave error never blocks the answer; the master always sees pready.
  // APB answer: one fixed wait state; pready registered so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h00000000;
      ap_pend_r <= 1'b0;
    end else begin
      pready    <= acc;
      ap_pend_r <= acc;
      pslverr   <= acc & ((sel == 7'h00) | ~setup_ok | (pwrite & sel[6]));
      prdata    <= 32'h00000000;
      if (acc & ~pwrite & setup_ok) begin
        case (1'b1)
          sel[0]:  prdata <= {30'h00000000, power_state_field};
          sel[1]:  prdata <= {28'h0000000, boost_r};
          sel[2]:  prdata <= {29'h00000000, en_r};
          sel[3]:  prdata <= {25'h0000000, lvl_r[6:0]};
          sel[4]:  prdata <= {25'h0000000, lvl_r[13:7]};
          sel[5]:  prdata <= {25'h0000000, lvl_r[20:14]};
          sel[6]:  prdata <= {28'h0000000, state_r};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Channel outputs follow the next state rather than the current one, so they
  // switch at the same edge as the mode field and a monitor never sees an
  // output driving while the field already reads low power or shutdown.
  // In active a disabled channel with a zero code is pulled low; with any
  // other code it floats, so a parked nonzero code does not load the line.
  // The level bus keeps tracking the register outside active so that the
  // analog side sees the right code the moment the channel is enabled.
  // Outputs float during reset, as in shutdown.
  // Output control per channel, one copy per channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ch
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_drive[g]             <= 1'b0;
          out_pulldown[g]          <= 1'b0;
          out_hiz[g]               <= 1'b1;
          out_level[7*g+6:7*g]     <= `TBC_LEVEL_RST;
        end else if (state_nxt == ST_ACT) begin
          // Live code tracks the register at once
          out_level[7*g+6:7*g] <= lvl_r[7*g+6:7*g];
          out_drive[g]         <= en_r[g];
          out_pulldown[g]      <= ~en_r[g] & (lvl_r[7*g+6:7*g] == 7'h00);
          out_hiz[g]           <= ~en_r[g] & (lvl_r[7*g+6:7*g] != 7'h00);
        end else begin
          // Shutdown, startup and low power all float the outputs
          out_drive[g]         <= 1'b0;
          out_pulldown[g]      <= 1'b0;
          out_hiz[g]           <= 1'b1;
          out_level[7*g+6:7*g] <= lvl_r[7*g+6:7*g];
        end
      end
    end
  endgenerate

  // Boost and serial indications also follow the next state, for the same
  // reason as the channels. The rail figure is the nominal target only; the
  // analog loop may sit a little above or below it under load.
  // The reset value of the rail figure matches the reset boost code, so the
  // code and the figure agree from the very first cycle.
  // Boost, serial and mode indication
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_en           <= 1'b0;
      boost_code         <= `TBC_BOOST_RST;
      boosted_rail_volts <= `TBC_BOOST_BASE_V + {4'h0, `TBC_BOOST_RST} * `TBC_BOOST_STEP_V;
      serial_on          <= 1'b0;
      power_state_field  <= `TBC_PM_SHUTDOWN;
    end else begin
      // Boost runs in startup and active only
      boost_en   <= (state_nxt == ST_START) | (state_nxt == ST_ACT);
      boost_code <= boost_r;
      // Nominal rail target in volts for observation
      boosted_rail_volts <= `TBC_BOOST_BASE_V + {4'h0, boost_r} * `TBC_BOOST_STEP_V;
      // Bus logic held in reset during shutdown
      serial_on <= (state_nxt != ST_SHUT);
      case (state_nxt)
        ST_START: power_state_field <= `TBC_PM_STARTUP;
        ST_ACT:   power_state_field <= `TBC_PM_ACTIVE;
        ST_LOW:   power_state_field <= `TBC_PM_LOWPWR;
        default:  power_state_field <= `TBC_PM_SHUTDOWN;
      endcase
    end
  end

endmodule // tbc_ctrl

`default_nettype wire

// ===== tbc_map.vh
// Register map, field layout, reset values and timing counts for the bias mode controller
`ifndef TBC_MAP_VH
`define TBC_MAP_VH

// Register byte offsets on APB
`define TBC_OFF_MODE    12'h000
`define TBC_OFF_BOOST   12'h004
`define TBC_OFF_ENABLE  12'h008
`define TBC_OFF_LEVEL_A 12'h00C
`define TBC_OFF_LEVEL_B 12'h010
`define TBC_OFF_LEVEL_C 12'h014
`define TBC_OFF_STATUS  12'h018

// Power state field codes
`define TBC_PM_ACTIVE   2'h0
`define TBC_PM_STARTUP  2'h1
`define TBC_PM_LOWPWR   2'h2
`define TBC_PM_SHUTDOWN 2'h3

// Field widths
`define TBC_BOOST_W 4
`define TBC_LEVEL_W 7

// Reset values
`define TBC_BOOST_RST  4'hB
`define TBC_ENABLE_RST 3'h0
`define TBC_LEVEL_RST  7'h00

// Boost rail scale in volts: base for code zero, one volt per step
`define TBC_BOOST_BASE_V 8'h0D
`define TBC_BOOST_STEP_V 8'h01

// Output level step in millivolts
`define TBC_LEVEL_STEP_MV 16'h00BD

// Startup dwell, printed maximum in microseconds, and clock rate in MHz
`define TBC_STARTUP_US 300
`define TBC_CLK_MHZ    125
`define TBC_STARTUP_CYC (`TBC_STARTUP_US * `TBC_CLK_MHZ)

`endif

// ===== tbc_sync.v
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module tbc_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Data
  input  wire d_in,
  output wire q_out
);

  reg meta_r;  // First stage, read only by the second
  reg sync_r;  // Second stage, safe to use

  // Plain two-stage shift; reset to a constant only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule // tbc_sync

`default_nettype wire

// ===== tbc_ctrl_properties.sv
// Port-level checks of the bias mode controller
`timescale 1ns/1ps
`default_nettype none
module tbc_ctrl_properties #(
  parameter STARTUP_CYC = 8  // Startup dwell in cycles
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus handshake
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Supply and mode
  input wire logic        io_reference_supply,
  input wire logic [1:0]  power_state_field,
  input wire logic        serial_on,
  // Boost and outputs
  input wire logic        boost_en,
  input wire logic [3:0]  boost_code,
  input wire logic [7:0]  boosted_rail_volts,
  input wire logic [2:0]  out_drive,
  input wire logic [2:0]  out_pulldown,
  input wire logic [20:0] out_level,
  input wire logic [2:0]  out_hiz
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles spent in startup; a hung dwell shows as a runaway count
  logic [15:0] start_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) start_cnt_r <= 16'h0000;
    else if (power_state_field == 2'h1) start_cnt_r <= start_cnt_r + 16'h0001;
    else start_cnt_r <= 16'h0000;
  end
  chk_rail_map: assert property ($stable(boost_code) |->
    boosted_rail_volts == 8'h0D + {4'h0, boost_code}) else $error("rail off code");
  chk_startup_reset: assert property ((power_state_field == 2'h1)[*2] ##0 !$past(psel) |->
    boost_code == 4'hB && out_level == 21'h0) else $error("startup not reset");
  chk_shutdown_off: assert property ((power_state_field == 2'h3)[*2] |->
    out_hiz == 3'h7 && out_drive == 3'h0 && !boost_en) else $error("shutdown live");
  chk_supply_loss: assert property ($fell(io_reference_supply) |->
    ##[1:6] power_state_field == 2'h3) else $error("no shutdown on supply loss");
  chk_startup_hiz: assert property ((power_state_field == 2'h1)[*2] |->
    out_hiz == 3'h7 && boost_en && serial_on) else $error("startup outputs wrong");
  chk_bus_answer: assert property (psel && penable && !pready |=>
    pready ##1 !pready) else $error("bus answer wrong");
  chk_startup_len: assert property (start_cnt_r <= STARTUP_CYC + 2)
    else $error("startup too long");
  chk_pulldown_only: assert property (out_pulldown != 3'h0 |->
    power_state_field == 2'h0 && (out_pulldown & (out_drive | out_hiz)) == 3'h0)
    else $error("pull-down wrong");
  chk_drive_active: assert property (out_drive != 3'h0 |-> power_state_field == 2'h0)
    else $error("drive outside active");
  chk_lowpwr_hiz: assert property ((power_state_field == 2'h2)[*2] |->
    out_hiz == 3'h7 && !boost_en && serial_on) else $error("low power wrong");
  chk_lowpwr_keep: assert property ((power_state_field == 2'h2)[*2] ##0 !$past(psel) |->
    $stable(boost_code) && $stable(out_level)) else $error("low power lost state");
  cov_lowpwr: cover property (power_state_field == 2'h2);
  cov_pulldown: cover property (out_pulldown != 3'h0);
  cov_supply_loss: cover property ($fell(io_reference_supply));
endmodule // tbc_ctrl_properties
bind tbc_ctrl tbc_ctrl_properties #(.STARTUP_CYC(STARTUP_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .io_reference_supply(io_reference_supply), .power_state_field(power_state_field),
  .serial_on(serial_on), .boost_en(boost_en), .boost_code(boost_code),
  .boosted_rail_volts(boosted_rail_volts), .out_drive(out_drive),
  .out_pulldown(out_pulldown), .out_level(out_level), .out_hiz(out_hiz));
`default_nettype wire

// ===== tbc_host.sv
// Host controller model: APB master issuing register and mode requests
`timescale 1ns/1ps
`default_nettype none
module tbc_host (
  // Clock
  input  wire logic        pclk,
  // Requests
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  // Answers
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  // One transfer; mode writes are how software asks for power states
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;  // Released lines show no stale value
    pwdata <= ~d;
  endtask
endmodule // tbc_host
`default_nettype wire

// ===== tbc_ctrl_tb.sv
// Self-checking bench for the bias mode controller
`timescale 1ns/1ps
`default_nettype none
`include "tbc_map.vh"
module tbc_ctrl_tb;
  logic        pclk, presetn, io, psel, penable, pwrite, pready, pslverr, b_en, ser, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  b_code;
  logic [7:0]  rail;
  logic [2:0]  drv, pdn, hiz, en, pd_e;
  logic [20:0] lvl, keep;
  logic [1:0]  pm;
  logic [6:0]  lv [3];
  int          fail_count, n_compared;
  // Short startup dwell keeps the run brief
  tbc_ctrl #(.STARTUP_CYC(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_reference_supply(io), .boost_en(b_en),
    .boost_code(b_code), .boosted_rail_volts(rail), .out_drive(drv), .out_pulldown(pdn),
    .out_level(lvl), .out_hiz(hiz), .power_state_field(pm), .serial_on(ser));
  tbc_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  always #4 pclk = ~pclk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Register write, then let registered outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rd, err);
    repeat (2) @(posedge pclk);
  endtask
  task automatic wait_pm(input logic [1:0] v);
    int n;
    n = 0;
    while (pm !== v && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check("mode", pm, v);
  endtask
  // Lowest boost code that keeps the rail 2 V over the top output
  function automatic logic [3:0] rail_for(input logic [6:0] m);
    int v;
    v = (m * `TBC_LEVEL_STEP_MV + 2999) / 1000 - 13;
    return (v < 0) ? 4'h0 : 4'(v);
  endfunction
  task automatic apply_out();
    logic [6:0] m;
    m = lv[0];
    for (int i = 1; i < 3; i++) if (lv[i] > m) m = lv[i];
    wr(`TBC_OFF_BOOST, {28'h0, rail_for(m)});
    for (int i = 0; i < 3; i++) wr(`TBC_OFF_LEVEL_A + 12'(4 * i), {25'h0, lv[i]});
    wr(`TBC_OFF_ENABLE, {29'h0, en});
    for (int i = 0; i < 3; i++) pd_e[i] = !en[i] && lv[i] == 7'h00;
    check("rail", rail, 8'h0D + {4'h0, rail_for(m)});
    check("level", lvl, {lv[2], lv[1], lv[0]});
    check("drive", drv, en);
    check("pulldown", pdn, pd_e);
    check("hiz", hiz, 3'(~en & ~pd_e));
  endtask
  task automatic power_up();
    io <= 1'b1;
    wait_pm(`TBC_PM_STARTUP);
    check("start_hiz", hiz, 3'h7);
    check("start_on", b_en & ser, 1'b1);
    wait_pm(`TBC_PM_ACTIVE);
    u_host.xfer(1'b0, `TBC_OFF_BOOST, 32'h0, rd, err);
    check("boost_rst", rd, 32'h0000000B);
    u_host.xfer(1'b0, `TBC_OFF_LEVEL_A, 32'h0, rd, err);
    check("level_rst", rd, 32'h00000000);
  endtask
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    io = 1'b0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(31321));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check("shut_hiz", hiz, 3'h7);
    u_host.xfer(1'b0, `TBC_OFF_MODE, 32'h0, rd, err);
    check("shut_err", err, 1'b1);
    $display("test reset done");
    power_up();
    $display("test power up done");
    for (int c = 0; c < 16; c++) begin
      wr(`TBC_OFF_BOOST, 32'(c));
      check("rail", rail, 8'(13 + c));
    end
    $display("test boost done");
    lv = '{7'h00, 7'h7F, 7'h00};
    en = 3'h2;
    apply_out();
    lv = '{7'h00, 7'h00, 7'h01};
    en = 3'h5;
    apply_out();
    repeat (6) begin
      foreach (lv[i]) lv[i] = 7'($urandom);
      en = 3'($urandom);
      apply_out();
    end
    $display("test outputs done");
    keep = lvl;
    wr(`TBC_OFF_MODE, 32'h2);
    check("lp_mode", pm, `TBC_PM_LOWPWR);
    check("lp_out", {hiz, b_en, ser}, 5'h1D);
    wr(`TBC_OFF_MODE, 32'h3);
    check("lp_ignore", pm, `TBC_PM_LOWPWR);
    wr(`TBC_OFF_MODE, 32'h0);
    check("lp_exit", pm, `TBC_PM_ACTIVE);
    check("lp_keep", lvl, keep);
    wr(`TBC_OFF_MODE, 32'h3);
    check("act_ignore", pm, `TBC_PM_ACTIVE);
    u_host.xfer(1'b0, 12'h0FC, 32'h0, rd, err);
    check("unmapped_err", err, 1'b1);
    check("unmapped_rd", rd, 32'h00000000);
    $display("test low power done");
    wr(`TBC_OFF_MODE, 32'h1);
    wait_pm(`TBC_PM_STARTUP);
    check("soft_rst", {b_code, lvl}, {4'hB, 21'h0});
    wait_pm(`TBC_PM_ACTIVE);
    $display("test soft startup done");
    wr(`TBC_OFF_LEVEL_A, 32'h7F);
    io <= 1'b0;
    wait_pm(`TBC_PM_SHUTDOWN);
    check("shut_bus", ser, 1'b0);
    repeat (5) @(posedge pclk);
    power_up();
    $display("test supply loss done");
    report_and_stop();
  end
endmodule // tbc_ctrl_tb
`default_nettype wire
